// *** hw/pis_pkg.sv ***
// Purpose: shared constants for the priority interrupt controller and its peripheral end
// Assumes: one 10 MHz clock (aclk), synchronous active-low reset
// Notes: byte offsets are for the axi4-lite register window of the controller
package pis_pkg;
    // level structure
    localparam int NUM_LEVELS = 16;
    localparam int NUM_STD = 3;
    localparam int NUM_SUB = 64;
    localparam int LVL_W = 4;
    localparam int SUB_W = 6;
    localparam logic [LVL_W-1:0] LVL_TRAP = 4'h0;
    localparam logic [LVL_W-1:0] LVL_XFER = 4'h1;
    localparam logic [LVL_W-1:0] LVL_EOR = 4'h2;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SWREQ = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_DEFER = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_PEND = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_XCONN_LO = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_XCONN_HI = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_ECONN_LO = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_ECONN_HI = 12'h01c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_ENTRY_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_RETURN_BASE = 12'h140;
    localparam logic [ADDR_W-1:0] OFF_SUBENT_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_SUBENT_END = 12'h400;
    // fields and reset values
    localparam int DEFER_EN_BIT = 4;
    localparam int NUM_EVT = 2;
    localparam int EVT_SWITCH = 0;
    localparam int EVT_TRAP = 1;
    localparam logic [NUM_LEVELS-1:0] ENABLE_RST = 16'h0000;
    localparam logic [4:0] DEFER_RST = 5'h00;
    localparam logic [NUM_EVT-1:0] MASK_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/pis_if.sv ***
// Purpose: party-line link between interrupt controller and peripheral controllers
// Assumes: both ends on aclk
// Notes: one request wire per device per party line, gated by the connect masks
`timescale 1ns/1ps
interface pis_if;
    import pis_pkg::*;
    logic [NUM_SUB-1:0] xfer_req;
    logic [NUM_SUB-1:0] eor_req;
    logic [NUM_SUB-1:0] xfer_conn;
    logic [NUM_SUB-1:0] eor_conn;
    logic ack_valid;
    logic ack_line;
    logic [SUB_W-1:0] ack_sub;
    modport ctrl (input xfer_req, eor_req,
                  output xfer_conn, eor_conn, ack_valid, ack_line, ack_sub);
    modport periph (output xfer_req, eor_req,
                    input xfer_conn, eor_conn, ack_valid, ack_line, ack_sub);
endinterface

// *** hw/pis_periph_end.sv ***
// Purpose: peripheral-controller end of the two party lines
// Assumes: need pulses come from logic on aclk
// Notes: a device request stays pending until the controller acknowledges it
`timescale 1ns/1ps
module pis_periph_end import pis_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // device side
    input wire logic [NUM_SUB-1:0] need_xfer,
    input wire logic [NUM_SUB-1:0] need_eor,
    output logic [NUM_SUB-1:0] xfer_wait,
    output logic [NUM_SUB-1:0] eor_wait,
    // party lines
    pis_if.periph pl
);
    logic [NUM_SUB-1:0] xwait_next;
    logic [NUM_SUB-1:0] ewait_next;

    // per-device pending, set wins over the acknowledge
    for (genvar g = 0; g < NUM_SUB; g++) begin : g_dev
        logic ack_x;
        logic ack_e;
        assign ack_x = pl.ack_valid && !pl.ack_line && (pl.ack_sub == SUB_W'(g));
        assign ack_e = pl.ack_valid && pl.ack_line && (pl.ack_sub == SUB_W'(g));
        assign xwait_next[g] = need_xfer[g] || (xfer_wait[g] && !ack_x);
        assign ewait_next[g] = need_eor[g] || (eor_wait[g] && !ack_e);
    end

    // pending state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_wait <= '0;
            eor_wait <= '0;
        end else begin
            xfer_wait <= xwait_next;
            eor_wait <= ewait_next;
        end
    end

    // drive a line only while connected, so unconnected devices stay silent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pl.xfer_req <= '0;
            pl.eor_req <= '0;
        end else begin
            pl.xfer_req <= xwait_next & pl.xfer_conn;
            pl.eor_req <= ewait_next & pl.eor_conn;
        end
    end
endmodule

// *** hw/pis_ctrl_end.sv ***
// Purpose: priority interrupt controller with party-line sub-levels and context switch
// Assumes: core signals on aclk, expansion request pins asynchronous
// Notes: one service at a time; svc_done from the core releases the next switch
`timescale 1ns/1ps
// Summary of operation
// - three standard levels, expandable to sixteen
// - two standard levels ranked by 64 sub-levels
// - each level has entry and return words
// - winning request saves return, jumps to entry
// - per-level enable; disabled levels never serviced
// - software can raise any level request
// - defer one chosen level to queue end
// - missing optional instruction raises trap level
// - service-request instruction always raises trap level
// - two party lines, 64 devices each
// - only connected devices drive a party line
// - devices request transfers on first party line
// - devices signal end-of-record on second line
// - each sub-level has its own entry word
module pis_ctrl_end import pis_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // processor core
    input wire logic core_ready,
    input wire logic [WORD_W-1:0] core_pc,
    input wire logic unimpl_op,
    input wire logic exec_svc,
    input wire logic svc_done,
    output logic jump_valid,
    output logic [WORD_W-1:0] jump_addr,
    output logic [LVL_W-1:0] jump_level,
    // expansion level request pins
    input wire logic [NUM_LEVELS-1:NUM_STD] ext_req,
    // interrupt output
    output logic irq,
    // party lines
    pis_if.ctrl pl
);
    typedef enum logic {PIS_IDLE, PIS_BUSY} pis_state_e;

    pis_state_e state_reg;
    logic [NUM_LEVELS-1:0] enable_reg, pend_reg, pend_next, req_all, cand, dmask;
    logic [4:0] defer_reg;
    logic [NUM_SUB-1:0] xhit, ehit;
    logic [NUM_EVT-1:0] status_reg, status_next, mask_reg, evt;
    logic [WORD_W-1:0] entry_mem [NUM_LEVELS];
    logic [WORD_W-1:0] ret_mem [NUM_LEVELS];
    logic [WORD_W-1:0] sub_mem [2*NUM_SUB];
    logic [NUM_LEVELS-1:NUM_STD] ext_meta_reg, ext_sync_reg;
    logic aw_full, w_full, do_wr;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg, wmask, wr_old, wr_val, rd_val;
    logic [3:0] w_strb_reg;
    logic wr_err, rd_err, win_valid, sub_ok, do_switch, trap_set;
    logic [LVL_W-1:0] win_lvl;
    logic [SUB_W-1:0] win_sub;
    logic [WORD_W-1:0] win_addr;

    // register read decode, shared by the read channel and write merging
    function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (a == OFF_ENABLE) begin
            r[15:0] = enable_reg;
        end else if (a == OFF_SWREQ) begin
            r[15:0] = 16'h0000;
        end else if (a == OFF_DEFER) begin
            r[4:0] = defer_reg;
        end else if (a == OFF_PEND) begin
            r[15:0] = req_all;
        end else if (a == OFF_XCONN_LO) begin
            r[31:0] = pl.xfer_conn[31:0];
        end else if (a == OFF_XCONN_HI) begin
            r[31:0] = pl.xfer_conn[63:32];
        end else if (a == OFF_ECONN_LO) begin
            r[31:0] = pl.eor_conn[31:0];
        end else if (a == OFF_ECONN_HI) begin
            r[31:0] = pl.eor_conn[63:32];
        end else if (a == OFF_STATUS) begin
            r[1:0] = status_reg;
        end else if (a == OFF_MASK) begin
            r[1:0] = mask_reg;
        end else if (a >= OFF_ENTRY_BASE && a < OFF_RETURN_BASE) begin
            r[15:0] = entry_mem[a[5:2]];
        end else if (a >= OFF_RETURN_BASE && a < OFF_RETURN_BASE + 12'h040) begin
            r[15:0] = ret_mem[a[5:2]];
        end else if (a >= OFF_SUBENT_BASE && a < OFF_SUBENT_END) begin
            r[15:0] = sub_mem[a[8:2]];
        end else begin
            r[32] = 1'b1; // unmapped
        end
        return r;
    endfunction

    // write path: address and data latched in either order
    assign do_wr = aw_full && w_full && !s_bvalid;
    assign wr_val = (wr_old & ~wmask) | (w_data_reg & wmask);
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{w_strb_reg[b]}};
    end

    // decode in a process: it must rerun when a register changes, not only the address
    always_comb begin
        {wr_err, wr_old} = reg_read(aw_addr_reg);
        {rd_err, rd_val} = reg_read(s_araddr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            aw_full <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_awvalid && s_awready) begin
            s_awready <= 1'b0;
            aw_full <= 1'b1;
            aw_addr_reg <= s_awaddr;
        end else begin
            s_awready <= !aw_full;
            aw_full <= aw_full && !do_wr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_wready <= 1'b0;
            w_full <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_wvalid && s_wready) begin
            s_wready <= 1'b0;
            w_full <= 1'b1;
            w_data_reg <= s_wdata;
            w_strb_reg <= s_wstrb;
        end else begin
            s_wready <= !w_full;
            w_full <= w_full && !do_wr;
        end
    end

    // write response, slverr on an unmapped address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else if (do_wr) begin
            s_bvalid <= 1'b1;
            s_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_val;
            s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_rvalid) begin
            s_rvalid <= !s_rready;
        end else begin
            s_arready <= 1'b1;
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= ENABLE_RST;
            defer_reg <= DEFER_RST;
            mask_reg <= MASK_RST;
            pl.xfer_conn <= '0;
            pl.eor_conn <= '0;
        end else if (do_wr) begin
            if (aw_addr_reg == OFF_ENABLE) enable_reg <= wr_val[15:0];
            if (aw_addr_reg == OFF_DEFER) defer_reg <= wr_val[4:0];
            if (aw_addr_reg == OFF_MASK) mask_reg <= wr_val[1:0];
            // connect masks pick which devices may share each line
            if (aw_addr_reg == OFF_XCONN_LO) pl.xfer_conn[31:0] <= wr_val;
            if (aw_addr_reg == OFF_XCONN_HI) pl.xfer_conn[63:32] <= wr_val;
            if (aw_addr_reg == OFF_ECONN_LO) pl.eor_conn[31:0] <= wr_val;
            if (aw_addr_reg == OFF_ECONN_HI) pl.eor_conn[63:32] <= wr_val;
        end
    end

    // vector words; a context switch beats a bus write to any return word in the same cycle
    always_ff @(posedge aclk) begin
        if (do_wr && aw_addr_reg >= OFF_ENTRY_BASE && aw_addr_reg < OFF_RETURN_BASE)
            entry_mem[aw_addr_reg[5:2]] <= wr_val[15:0];
        if (do_wr && aw_addr_reg >= OFF_SUBENT_BASE && aw_addr_reg < OFF_SUBENT_END)
            sub_mem[aw_addr_reg[8:2]] <= wr_val[15:0];
        if (do_switch) begin
            ret_mem[win_lvl] <= core_pc;
        end else if (do_wr && aw_addr_reg >= OFF_RETURN_BASE
                     && aw_addr_reg < OFF_RETURN_BASE + 12'h040) begin
            ret_mem[aw_addr_reg[5:2]] <= wr_val[15:0];
        end
    end

    // expansion pins cross into aclk through two flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
        end else begin
            ext_meta_reg <= ext_req;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // request gathering: party lines are level requests, the rest are sticky
    assign xhit = pl.xfer_req & pl.xfer_conn;
    assign ehit = pl.eor_req & pl.eor_conn;
    assign trap_set = unimpl_op || exec_svc;
    assign req_all = pend_reg | {{(NUM_LEVELS-NUM_STD){1'b0}}, |ehit, |xhit, 1'b0};
    assign cand = req_all & enable_reg;

    // winner search: undeferred levels first, then the deferred one, lowest index wins
    // deferring a whole tail of levels would change nothing, so only the chosen level moves
    always_comb begin
        win_valid = 1'b0;
        win_lvl = '0;
        win_sub = '0;
        for (int i = 0; i < NUM_LEVELS; i++) begin
            dmask[i] = defer_reg[DEFER_EN_BIT] && (LVL_W'(i) == defer_reg[3:0]);
        end
        for (int i = 0; i < NUM_LEVELS; i++) begin
            if (!win_valid && cand[i] && !dmask[i]) begin
                win_valid = 1'b1;
                win_lvl = LVL_W'(i);
            end
        end
        for (int i = 0; i < NUM_LEVELS; i++) begin
            if (!win_valid && cand[i] && dmask[i]) begin
                win_valid = 1'b1;
                win_lvl = LVL_W'(i);
            end
        end
        sub_ok = 1'b0;
        for (int s = NUM_SUB - 1; s >= 0; s--) begin
            if ((win_lvl == LVL_XFER && xhit[s]) || (win_lvl == LVL_EOR && ehit[s])) begin
                sub_ok = 1'b1;
                win_sub = SUB_W'(s);
            end
        end
        // a software-raised party-line request with no device uses the level word
        win_addr = sub_ok ? sub_mem[{win_lvl == LVL_EOR, win_sub}] : entry_mem[win_lvl];
    end

    assign do_switch = (state_reg == PIS_IDLE) && win_valid && core_ready;

    // pending bits: the set wins over the clear of the serviced level
    always_comb begin
        pend_next = pend_reg;
        if (do_switch) pend_next[win_lvl] = 1'b0;
        if (do_wr && aw_addr_reg == OFF_SWREQ) pend_next = pend_next | wr_val[15:0];
        pend_next[LVL_TRAP] = pend_next[LVL_TRAP] || trap_set;
        pend_next[NUM_LEVELS-1:NUM_STD] = pend_next[NUM_LEVELS-1:NUM_STD] | ext_sync_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) pend_reg <= '0;
        else pend_reg <= pend_next;
    end

    // context switch sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= PIS_IDLE;
            jump_valid <= 1'b0;
            jump_addr <= '0;
            jump_level <= '0;
            pl.ack_valid <= 1'b0;
            pl.ack_line <= 1'b0;
            pl.ack_sub <= '0;
        end else begin
            jump_valid <= do_switch;
            pl.ack_valid <= do_switch && sub_ok;
            case (state_reg)
                PIS_IDLE: begin
                    if (do_switch) begin
                        state_reg <= PIS_BUSY;
                        jump_addr <= win_addr;
                        jump_level <= win_lvl;
                        pl.ack_line <= (win_lvl == LVL_EOR);
                        pl.ack_sub <= win_sub;
                    end
                end
                PIS_BUSY: begin
                    if (svc_done) state_reg <= PIS_IDLE;
                end
                default: state_reg <= PIS_IDLE;
            endcase
        end
    end

    // event status: write one to clear, a new event in the same cycle wins
    assign evt[EVT_SWITCH] = do_switch;
    assign evt[EVT_TRAP] = trap_set;
    always_comb begin
        status_next = status_reg;
        if (do_wr && aw_addr_reg == OFF_STATUS) status_next = status_next & ~wr_val[1:0];
        status_next = status_next | evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= '0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end
endmodule

// *** test/pis_sva.sv ***
// Purpose: party-line checks between controller end and peripheral end
// Assumes: one clock, synchronous active-low reset
// Notes: masks are also taken one edge back, so either gating latency passes
`timescale 1ns/1ps
module pis_sva import pis_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // party lines
    input wire logic [NUM_SUB-1:0] xfer_req,
    input wire logic [NUM_SUB-1:0] eor_req,
    input wire logic [NUM_SUB-1:0] xfer_conn,
    input wire logic [NUM_SUB-1:0] eor_conn,
    input wire logic ack_valid,
    input wire logic ack_line,
    input wire logic [SUB_W-1:0] ack_sub
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // acknowledge on either line
    sequence s_xack;
        ack_valid && !ack_line;
    endsequence
    sequence s_eack;
        ack_valid && ack_line;
    endsequence
    // devices ranked above the acknowledged one
    logic [NUM_SUB-1:0] above;
    assign above = (64'h1 << ack_sub) - 64'h1;
    a_xfer_gated: assert property ((xfer_req & ~xfer_conn & ~$past(xfer_conn)) == 64'h0)
        else $error("transfer line driven by unconnected device");
    a_eor_gated: assert property ((eor_req & ~eor_conn & ~$past(eor_conn)) == 64'h0)
        else $error("end-of-record line driven by unconnected device");
    a_ack_one_cycle: assert property (ack_valid |=> !ack_valid)
        else $error("acknowledge longer than one cycle");
    a_xack_has_req: assert property (s_xack |-> xfer_req[ack_sub])
        else $error("transfer acknowledge without request");
    a_eack_has_req: assert property (s_eack |-> eor_req[ack_sub])
        else $error("end-of-record acknowledge without request");
    a_xack_lowest: assert property (s_xack |->
        ($past(xfer_req) & $past(xfer_conn) & above) == 0)
        else $error("transfer acknowledge skipped a higher device");
    a_eack_lowest: assert property (s_eack |->
        ($past(eor_req) & $past(eor_conn) & above) == 0)
        else $error("end-of-record acknowledge skipped a higher device");
    a_xack_clears: assert property (s_xack |=> !xfer_req[$past(ack_sub)])
        else $error("transfer request held after acknowledge");
    a_eack_clears: assert property (s_eack |=> !eor_req[$past(ack_sub)])
        else $error("end-of-record request held after acknowledge");
endmodule

// *** test/priority_interrupt_system_bench.sv ***
// Purpose: register, trap, party-line and priority tests of both ends
// Assumes: aclk 10 MHz, reset held 10 cycles
// Notes: handshakes are sampled right after the edge, before its updates land
`timescale 1ns/1ps
module priority_interrupt_system_bench;
    import pis_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, jump_valid, irq;
    logic [1:0] s_bresp, s_rresp;
    logic core_ready = 1'b0, unimpl_op = 1'b0, exec_svc = 1'b0, svc_done = 1'b0;
    logic [WORD_W-1:0] core_pc = 16'h0abc, jump_addr;
    logic [LVL_W-1:0] jump_level;
    logic [NUM_LEVELS-1:NUM_STD] ext_req = '0;
    logic [NUM_SUB-1:0] need_xfer = '0, need_eor = '0, xfer_wait, eor_wait;
    int mismatches = 0, checks = 0, cyc = 0;
    // clock
    always #50 aclk = ~aclk;
    pis_if u_pis_if ();
    pis_ctrl_end u_pis_ctrl_end (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .core_ready, .core_pc,
        .unimpl_op, .exec_svc, .svc_done, .jump_valid, .jump_addr, .jump_level, .ext_req,
        .irq, .pl(u_pis_if));
    pis_periph_end u_pis_periph_end (.aclk, .aresetn, .need_xfer, .need_eor, .xfer_wait,
        .eor_wait, .pl(u_pis_if));
    pis_sva u_pis_sva (.aclk, .aresetn, .xfer_req(u_pis_if.xfer_req),
        .eor_req(u_pis_if.eor_req), .xfer_conn(u_pis_if.xfer_conn),
        .eor_conn(u_pis_if.eor_conn), .ack_valid(u_pis_if.ack_valid),
        .ack_line(u_pis_if.ack_line), .ack_sub(u_pis_if.ack_sub));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard: the tests need about a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                check($sformatf("bresp %h", a), s_bresp, er);
                s_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                check($sformatf("rdata %h", a), s_rdata, ed);
                check($sformatf("rresp %h", a), s_rresp, er);
                s_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // wait for one context switch, check it, then end the routine
    task automatic sw(input logic [LVL_W-1:0] el, input logic [WORD_W-1:0] ea);
        int n;
        n = 0;
        while (jump_valid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        check("jump_level", jump_level, el);
        check("jump_addr", jump_addr, ea);
        svc_done <= 1'b1;
        @(posedge aclk);
        check("jump_valid pulse", jump_valid, 1'b0);
        svc_done <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFF_ENABLE, 32'h0, RESP_OKAY);
        rd(OFF_PEND, 32'h0, RESP_OKAY);
        rd(OFF_DEFER, 32'h0, RESP_OKAY);
        rd(OFF_MASK, 32'h0, RESP_OKAY);
        rd(12'h030, 32'h0, RESP_SLVERR);
        wr(12'h030, 32'h1, RESP_SLVERR);
        for (int l = 0; l < NUM_LEVELS; l++) begin
            wr(12'(OFF_ENTRY_BASE + 4 * l), 32'h1000 + l, RESP_OKAY);
        end
        for (int k = 0; k < 2 * NUM_SUB; k++) begin
            wr(12'(OFF_SUBENT_BASE + 4 * k), 32'h2000 + k, RESP_OKAY);
        end
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        wr(OFF_ENABLE, 32'hffff, RESP_OKAY);
        $display("test registers done");
        // traps from a missing instruction and from a service call
        core_ready <= 1'b1;
        unimpl_op <= 1'b1;
        @(posedge aclk);
        unimpl_op <= 1'b0;
        sw(LVL_TRAP, 16'h1000);
        rd(OFF_RETURN_BASE, 32'h0abc, RESP_OKAY);
        exec_svc <= 1'b1;
        @(posedge aclk);
        exec_svc <= 1'b0;
        sw(LVL_TRAP, 16'h1000);
        rd(OFF_STATUS, 32'h3, RESP_OKAY);
        check("irq", irq, 1'b1);
        wr(OFF_MASK, 32'h0, RESP_OKAY);
        rd(OFF_PEND, 32'h0, RESP_OKAY);
        check("irq masked", irq, 1'b0);
        wr(OFF_STATUS, 32'h3, RESP_OKAY);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        $display("test traps done");
        // party lines: devices 5 and 9 and unconnected 7 on line 1, device 3 on line 2
        core_ready <= 1'b0;
        wr(OFF_XCONN_LO, 32'h220, RESP_OKAY);
        wr(OFF_ECONN_LO, 32'h8, RESP_OKAY);
        need_xfer <= 64'h2a0;
        need_eor <= 64'h8;
        @(posedge aclk);
        need_xfer <= '0;
        need_eor <= '0;
        repeat (3) @(posedge aclk);
        check("xfer_wait", xfer_wait, 64'h2a0);
        check("xfer_req", u_pis_if.xfer_req, 64'h220);
        check("eor_req", u_pis_if.eor_req, 64'h8);
        rd(OFF_PEND, 32'h6, RESP_OKAY);
        core_ready <= 1'b1;
        sw(LVL_XFER, 16'h2005);
        sw(LVL_XFER, 16'h2009);
        sw(LVL_EOR, 16'h2043);
        check("wait left", xfer_wait, 64'h80);
        check("eor_wait", eor_wait, 64'h0);
        wr(OFF_XCONN_LO, 32'ha0, RESP_OKAY);
        sw(LVL_XFER, 16'h2007);
        // top device of the second line, through the upper connect word
        wr(OFF_ECONN_HI, 32'h8000_0000, RESP_OKAY);
        rd(OFF_ECONN_HI, 32'h8000_0000, RESP_OKAY);
        need_eor <= 64'h8000_0000_0000_0000;
        @(posedge aclk);
        need_eor <= '0;
        sw(LVL_EOR, 16'h207f);
        $display("test party lines done");
        // software and expansion requests with level 3 disabled
        core_ready <= 1'b0;
        wr(OFF_ENABLE, 32'hfff7, RESP_OKAY);
        wr(OFF_SWREQ, 32'h1008, RESP_OKAY);
        ext_req <= 13'h1000;
        repeat (4) @(posedge aclk);
        ext_req <= '0;
        repeat (4) @(posedge aclk);
        rd(OFF_SWREQ, 32'h0, RESP_OKAY);
        rd(OFF_PEND, 32'h9008, RESP_OKAY);
        core_ready <= 1'b1;
        sw(4'hc, 16'h100c);
        sw(4'hf, 16'h100f);
        rd(OFF_PEND, 32'h8, RESP_OKAY);
        // only lane 0 written, the upper enables must survive the merge
        s_wstrb <= 4'h1;
        wr(OFF_ENABLE, 32'h0000_00ff, RESP_OKAY);
        s_wstrb <= 4'hf;
        sw(4'h3, 16'h1003);
        rd(OFF_ENABLE, 32'hffff, RESP_OKAY);
        $display("test levels done");
        // level 4 deferred, so level 9 is served first
        core_ready <= 1'b0;
        wr(OFF_SWREQ, 32'h0210, RESP_OKAY);
        wr(OFF_DEFER, 32'h14, RESP_OKAY);
        rd(OFF_DEFER, 32'h14, RESP_OKAY);
        core_ready <= 1'b1;
        sw(4'h9, 16'h1009);
        sw(4'h4, 16'h1004);
        rd(OFF_STATUS, 32'h1, RESP_OKAY);
        check("irq still masked", irq, 1'b0);
        $display("test deferral done");
        wrap_up();
    end
endmodule
